/* hdl/dtp_regs.vh */
// Register offsets, field positions, reset values and timing counts of the down timer.
`ifndef DTP_REGS_VH
`define DTP_REGS_VH
`define DTP_PRESCALER_VALUE_IDX    8'hd2
`define DTP_COUNT_VALUE_IDX        8'hd3
`define DTP_TIMER_CONTROL_IDX      8'hd4
`define DTP_IRQ_STATUS_IDX         8'hd5
`define DTP_IRQ_MASK_IDX           8'hd6
`define DTP_ADDR_PRESCALER_VALUE   12'h348
`define DTP_ADDR_COUNT_VALUE       12'h34c
`define DTP_ADDR_TIMER_CONTROL     12'h350
`define DTP_ADDR_IRQ_STATUS        12'h354
`define DTP_ADDR_IRQ_MASK          12'h358
`define DTP_BIT_ZERO_FLAG          7
`define DTP_BIT_IRQ_ENABLE         6
`define DTP_BIT_PIN_DIRECTION      5
`define DTP_BIT_PIN_LEVEL          4
`define DTP_BIT_PRESCALER_RUN      3
`define DTP_TAP_HI                 2
`define DTP_TAP_LO                 0
`define DTP_PRESCALER_RESET        7'h7f
`define DTP_COUNT_RESET            8'hff
`define DTP_CONTROL_RESET          8'h00
`define DTP_INT_DIVIDE             4'hc
`define DTP_INT_DIVIDE_LAST        4'hb
`endif

/* hdl/dtp_timer.v */
// APB down timer with a seven bit prescaler, pin modes and zero interrupt.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "dtp_regs.vh"

module dtp_timer (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        timer_pin_in,
   output reg         timer_pin_out,
   output reg         timer_pin_oe,
   output reg         timer_irq,
   output reg         wake_request,
   output reg         irq
);

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   reg  [6:0]  prescaler_value;
   reg  [7:0]  count_value;
   reg  [7:0]  timer_control_status;
   reg  [1:0]  irq_status;
   reg  [1:0]  irq_mask;
   reg  [3:0]  div_count;
   reg         pin_meta;
   reg         pin_sync;
   reg         pin_prev;
   reg         pin_latch;
   reg  [6:0]  next_psc_value;
   reg  [7:0]  next_count_value;
   reg  [7:0]  next_control;
   reg  [31:0] next_prdata;
   reg         next_pin_out;

   // ----------------------------------------------------------------
   // Field aliases.
   // ----------------------------------------------------------------
   wire        zero_reached_flag    = timer_control_status[`DTP_BIT_ZERO_FLAG];
   wire        zero_irq_enable      = timer_control_status[`DTP_BIT_IRQ_ENABLE];
   wire        pin_direction_select = timer_control_status[`DTP_BIT_PIN_DIRECTION];
   wire        pin_level            = timer_control_status[`DTP_BIT_PIN_LEVEL];
   wire        prescaler_run        = timer_control_status[`DTP_BIT_PRESCALER_RUN];
   wire [2:0]  tap_select           = timer_control_status[`DTP_TAP_HI:`DTP_TAP_LO];

   // ----------------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------------
   wire        access   = psel & penable & pready;
   wire        wr       = access & pwrite;
   wire        hit_psc  = (paddr == `DTP_ADDR_PRESCALER_VALUE);
   wire        hit_cnt  = (paddr == `DTP_ADDR_COUNT_VALUE);
   wire        hit_ctl  = (paddr == `DTP_ADDR_TIMER_CONTROL);
   wire        hit_sts  = (paddr == `DTP_ADDR_IRQ_STATUS);
   wire        hit_msk  = (paddr == `DTP_ADDR_IRQ_MASK);
   wire        mapped   = hit_psc | hit_cnt | hit_ctl | hit_sts | hit_msk;
   wire        setup    = psel & ~penable;
   wire        rd_setup = setup & ~pwrite;

   // ----------------------------------------------------------------
   // Write strobes.
   // ----------------------------------------------------------------
   wire        wr_psc   = wr & hit_psc;
   wire        wr_cnt   = wr & hit_cnt;
   wire        wr_ctl   = wr & hit_ctl;
   wire        wr_sts   = wr & hit_sts;
   wire        wr_msk   = wr & hit_msk;

   // ----------------------------------------------------------------
   // Prescaler clock source.
   // ----------------------------------------------------------------
   wire        div_tick  = (div_count == `DTP_INT_DIVIDE_LAST);
   wire        pin_rise  = pin_sync & ~pin_prev;
   reg         pre_tick;

   wire        mode_event  = ~pin_direction_select & ~pin_level;
   wire        mode_gated  = ~pin_direction_select & pin_level;
   wire        mode_output = pin_direction_select;

   always @* begin
      pre_tick = 1'b0;
      if (mode_event) begin
         pre_tick = pin_rise;
      end else if (mode_gated) begin
         pre_tick = div_tick & pin_sync;
      end else if (mode_output) begin
         pre_tick = div_tick;
      end
   end

   wire [6:0]  next_prescaler = prescaler_value - 7'h01;
   wire [7:0]  tap_rise;

   // ----------------------------------------------------------------
   // Tap edge detect, one detector per prescaler bit.
   // ----------------------------------------------------------------
   assign tap_rise[0] = 1'b1;
   genvar ti;
   generate
      for (ti = 1; ti < 8; ti = ti + 1) begin : g_tap
         assign tap_rise[ti] = ~prescaler_value[ti - 1] & next_prescaler[ti - 1];
      end
   endgenerate

   wire        count_tick     = prescaler_run & pre_tick & tap_rise[tap_select];

   // ----------------------------------------------------------------
   // Zero flag events.
   // ----------------------------------------------------------------
   wire [7:0]  next_count     = count_value - 8'h01;
   wire        hw_zero        = count_tick & (next_count == 8'h00) & ~wr_cnt;
   wire        sw_zero        = (wr_cnt & (pwdata[7:0] == 8'h00)) |
                                (wr_ctl & pwdata[`DTP_BIT_ZERO_FLAG]);
   wire        flag_event     = hw_zero | sw_zero;

   // ----------------------------------------------------------------
   // Pin synchroniser.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= timer_pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ----------------------------------------------------------------
   // Divide-by-12 source.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= 4'h0;
      end else if (div_tick) begin
         div_count <= 4'h0;
      end else begin
         div_count <= div_count + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler next value.
   // ----------------------------------------------------------------
   always @* begin
      next_psc_value = prescaler_value;
      if (!prescaler_run) begin
         next_psc_value = `DTP_PRESCALER_RESET;
      end else if (wr_psc) begin
         next_psc_value = pwdata[6:0];
      end else if (pre_tick) begin
         next_psc_value = next_prescaler;
      end
   end

   // ----------------------------------------------------------------
   // Counter next value.
   // ----------------------------------------------------------------
   always @* begin
      next_count_value = count_value;
      if (wr_cnt) begin
         next_count_value = pwdata[7:0];
      end else if (count_tick) begin
         next_count_value = next_count;
      end
   end

   // ----------------------------------------------------------------
   // Control next value.
   // ----------------------------------------------------------------
   always @* begin
      next_control = timer_control_status;
      if (wr_ctl) begin
         next_control = pwdata[7:0];
      end
      if (flag_event) begin
         next_control[`DTP_BIT_ZERO_FLAG] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and counter registers.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler_value <= `DTP_PRESCALER_RESET;
      end else begin
         prescaler_value <= next_psc_value;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value <= `DTP_COUNT_RESET;
      end else begin
         count_value <= next_count_value;
      end
   end

   // ----------------------------------------------------------------
   // Control register.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_status <= `DTP_CONTROL_RESET;
      end else begin
         timer_control_status <= next_control;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status set and clear terms.
   // ----------------------------------------------------------------
   wire [1:0]  sts_set = {sw_zero, hw_zero};
   wire [1:0]  sts_clr = wr_sts ? pwdata[1:0] : 2'b00;

   // ----------------------------------------------------------------
   // Output pin.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_latch <= 1'b0;
      end else if (zero_reached_flag) begin
         pin_latch <= pin_level;
      end
   end

   always @* begin
      next_pin_out = pin_latch;
      if (zero_reached_flag) begin
         next_pin_out = pin_level;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_pin_out <= 1'b0;
         timer_pin_oe  <= 1'b0;
      end else begin
         timer_pin_out <= next_pin_out;
         timer_pin_oe  <= pin_direction_select;
      end
   end

   // ----------------------------------------------------------------
   // Timer request.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq    <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         timer_irq    <= zero_reached_flag & zero_irq_enable;
         wake_request <= zero_reached_flag & zero_irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask.
   // ----------------------------------------------------------------
   genvar si;
   generate
      for (si = 0; si < 2; si = si + 1) begin : g_sts
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_status[si] <= 1'b0;
            end else if (sts_set[si]) begin
               irq_status[si] <= 1'b1;
            end else if (sts_clr[si]) begin
               irq_status[si] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= 2'b00;
      end else if (wr_msk) begin
         irq_mask <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // APB slave: no wait state, error on unmapped address.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // ----------------------------------------------------------------
   // Error response.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup & ~mapped;
      end
   end

   // ----------------------------------------------------------------
   // Read data select.
   // ----------------------------------------------------------------
   always @* begin
      next_prdata = 32'h00000000;
      if (rd_setup) begin
         case (paddr)
            `DTP_ADDR_PRESCALER_VALUE: next_prdata = {25'h0000000, prescaler_value};
            `DTP_ADDR_COUNT_VALUE:     next_prdata = {24'h000000, count_value};
            `DTP_ADDR_TIMER_CONTROL:   next_prdata = {24'h000000, timer_control_status};
            `DTP_ADDR_IRQ_STATUS:      next_prdata = {30'h00000000, irq_status};
            `DTP_ADDR_IRQ_MASK:        next_prdata = {30'h00000000, irq_mask};
            default:                   next_prdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data register.
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= next_prdata;
      end
   end

endmodule // dtp_timer

/* verification/dtp_pin_src.sv */
// Outside signal source that drives the timer pin when it is an input.
`timescale 1ns/100ps
module dtp_pin_src (
   input  wire       pclk,
   input  wire [1:0] pin_mode,
   output reg        pin_drive
);
   reg [4:0] cnt;
   initial begin
      cnt = 5'h0;
      pin_drive = 1'b0;
   end
   always @(posedge pclk) begin
      cnt       <= (pin_mode == 2'h2) ? cnt + 5'h1 : 5'h0;
      pin_drive <= (pin_mode == 2'h2) ? cnt[2] : pin_mode[0];
   end
endmodule // dtp_pin_src

/* verification/dtp_timer_asserts.sv */
// Port assertions for the down timer.
`timescale 1ns/100ps
module dtp_timer_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire        pready,
   input wire        pslverr,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        timer_pin_oe,
   input wire        timer_irq,
   input wire        wake_request
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire ctl_wr = psel && penable && pready && pwrite && paddr == 12'h350;
   wire mapped = paddr >= 12'h348 && paddr <= 12'h358 && paddr[1:0] == 2'h0;
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("data idle");
   a_rdata_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper bits set");
   a_unmapped_error: assert property (psel && !penable && !mapped |=> pslverr)
      else $error("no slave error");
   a_wake_with_irq: assert property (wake_request == timer_irq) else $error("wake");
   a_oe_from_dir: assert property (ctl_wr |-> ##2 timer_pin_oe == $past(pwdata[5], 2))
      else $error("pin enable");
   a_irq_on_flag: assert property (ctl_wr && pwdata[7:6] == 2'h3 |-> ##2 timer_irq)
      else $error("no request");
   cover property (pslverr);
   cover property ($rose(timer_irq));
   cover property ($rose(timer_pin_oe));
endmodule // dtp_timer_chk
bind dtp_timer dtp_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq),
   .wake_request(wake_request));

/* verification/tb.sv */
// Self-checking bench for the down timer.
`timescale 1ns/100ps
module tb;
   reg         pclk, presetn, psel, penable, pwrite, rd_err;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd_data;
   reg  [1:0]  pin_mode;
   wire [31:0] prdata;
   wire        pready, pslverr, pin_out, pin_oe, t_irq, wake, irq, pin_src;
   wire        pin = pin_oe ? pin_out : pin_src;
   integer     error_cnt, compares;
   dtp_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_pin_in(pin), .timer_pin_out(pin_out), .timer_pin_oe(pin_oe),
      .timer_irq(t_irq), .wake_request(wake), .irq(irq));
   dtp_pin_src u_src (.pclk(pclk), .pin_mode(pin_mode), .pin_drive(pin_src));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task chk(input string what, input [31:0] seen, input [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task test_done;
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input [11:0] a, input [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), rd_data, e);
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      error_cnt = error_cnt + 1;
      test_done;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pin_mode} = 0;
      error_cnt = 0;
      compares = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h348, 32'h7f);
      rd(12'h34c, 32'hff);
      rd(12'h350, 32'h0);
      apb(1'b0, 12'h0, 32'h0);
      chk("slverr", rd_err, 1'b1);
      wr(12'h348, 32'h10);
      rd(12'h348, 32'h7f);
      wr(12'h34c, 32'h0);
      rd(12'h350, 32'h80);
      repeat (2) @(posedge pclk);
      chk("irq", irq, 1'b0);
      wr(12'h358, 32'h3);
      repeat (2) @(posedge pclk);
      chk("irq", irq, 1'b1);
      wr(12'h354, 32'h3);
      repeat (2) @(posedge pclk);
      chk("irq", irq, 1'b0);
      wr(12'h350, 32'hc0);
      repeat (2) @(posedge pclk);
      chk("timer irq", t_irq, 1'b1);
      chk("wake", wake, 1'b1);
      wr(12'h350, 32'h8);
      wr(12'h348, 32'h5);
      rd(12'h348, 32'h5);
      wr(12'h34c, 32'h4);
      pin_mode <= 2'h2;
      repeat (32) @(posedge pclk);
      pin_mode <= 2'h0;
      repeat (8) @(posedge pclk);
      rd(12'h34c, 32'h0);
      rd(12'h350, 32'h88);
      wr(12'h350, 32'h18);
      wr(12'h34c, 32'h2);
      repeat (40) @(posedge pclk);
      rd(12'h34c, 32'h2);
      pin_mode <= 2'h1;
      repeat (40) @(posedge pclk);
      rd(12'h350, 32'h98);
      wr(12'h350, 32'h38);
      wr(12'h34c, 32'h0);
      repeat (3) @(posedge pclk);
      chk("pin", pin, 1'b1);
      wr(12'h350, 32'h28);
      repeat (3) @(posedge pclk);
      chk("pin", pin, 1'b1);
      wr(12'h350, 32'h27);
      wr(12'h34c, 32'h5);
      wr(12'h350, 32'h2f);
      wr(12'h348, 32'h1);
      repeat (60) @(posedge pclk);
      rd(12'h34c, 32'h4);
      test_done;
   end
endmodule // tb
